// ===== core/freq_disc_pkg.sv
// shared constants and types of the carrier frequency discriminator block
package freq_disc_pkg;
  localparam int REG_W = 8;
  localparam int BUS_W = 32;
  // register indices; the byte address is four times the index
  localparam logic [31:0] IDX_DLY = 32'h0000_0004;
  localparam logic [31:0] IDX_FED = 32'h0000_0005;
  localparam logic [31:0] IDX_CLF = 32'h0000_0006;
  localparam logic [31:0] ADDR_DLY = IDX_DLY << 2;
  localparam logic [31:0] ADDR_FED = IDX_FED << 2;
  localparam logic [31:0] ADDR_CLF = IDX_CLF << 2;
  localparam logic [REG_W-1:0] RST_DLY = 8'h00;
  localparam logic [REG_W-1:0] RST_FED = 8'h00;
  localparam logic [REG_W-1:0] RST_CLF = 8'h00;
  // field layout
  localparam int K_LSB = 0;
  localparam int K_W = 3;
  localparam int SH_LSB = 0;
  localparam int SH_W = 3;
  localparam int OFS_LSB = 3;
  localparam int OFS_W = 5;
  localparam int ROUTE_BIT = 6;
  localparam logic [K_W-1:0] K_MAX = 3'h4;
  localparam logic [SH_W-1:0] SH_MAX = 3'h4;
  // bus codes
  localparam logic [1:0] TR_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_DLY = 2'h1,
    SEL_FED = 2'h2,
    SEL_CLF = 2'h3
  } reg_sel_t;
endpackage

// ===== core/phase_delay_mem.sv
// small phase history memory with registered read data
`timescale 1ns/1ns
module phase_delay_mem #(
  parameter int W = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // read side
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } mem_state_t;

  mem_state_t st_r;
  mem_state_t st_nxt;

  // read before write, so a full-depth delay sees the oldest word
  always_comb begin
    st_nxt = st_r;
    if (rd_en) begin
      st_nxt.rd = st_r.mem[rd_addr];
    end
    if (wr_en) begin
      st_nxt.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd;
endmodule

// ===== core/carrier_freq_discriminator_cfg.sv
// carrier frequency discriminator, error shift and serial output routing with its registers
// How it works
// - frequency estimate is present phase minus a delayed earlier phase sample
// - 3-bit field K selects a delay of two to the K samples, 1 to 16
// - the delay length sets discriminator gain; longer delay, larger output
// - frequency offset is a 5-bit fractional two's complement value, msb weighs -1
// - offset is added with wrap-around, never saturating
// - offset lines up with the five top bits of the discriminator output
// - frequency error result is shifted left by a 3-bit count, zero to four
// - routing bit clear sends the lag accumulator alone to serial output
// - routing bit set sends lead plus lag sum to serial output
`timescale 1ns/1ns
module carrier_freq_discriminator_cfg
  import freq_disc_pkg::*;
#(
  parameter int PW = 16,
  parameter int LW = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [BUS_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [BUS_W-1:0] hrdata,
  // phase samples from the polar converter
  input wire logic phase_valid,
  input wire logic [PW-1:0] phase_in,
  // frequency results
  output logic disc_valid,
  output logic [PW-1:0] disc_out,
  output logic [PW-1:0] ferr_out,
  // carrier loop filter terms and serial output path
  input wire logic [LW-1:0] lead_in,
  input wire logic [LW-1:0] lag_in,
  output logic [LW-1:0] ser_out
);
  typedef struct packed {
    logic [REG_W-1:0] dly;
    logic [REG_W-1:0] fed;
    logic [REG_W-1:0] clf;
    logic dp_wr;
    reg_sel_t dp_sel;
    logic [BUS_W-1:0] rdata;
    logic [AW-1:0] wptr;
    logic [PW-1:0] cur;
    logic v1;
    logic [PW-1:0] disc;
    logic [PW-1:0] ferr;
    logic v2;
    logic [LW-1:0] ser;
  } state_t;

  localparam state_t ST_RST = '{
    dly: RST_DLY,
    fed: RST_FED,
    clf: RST_CLF,
    dp_wr: 1'b0,
    dp_sel: SEL_NONE,
    rdata: '0,
    wptr: '0,
    cur: '0,
    v1: 1'b0,
    disc: '0,
    ferr: '0,
    v2: 1'b0,
    ser: '0
  };

  state_t st_r;
  state_t st_nxt;

  logic addr_ok;
  logic [K_W-1:0] k_fld;
  logic [K_W-1:0] k_eff;
  logic [SH_W-1:0] sh_fld;
  logic [OFS_W-1:0] ofs_fld;
  logic [PW-1:0] ofs_ext;
  logic route;
  logic [AW-1:0] rd_addr;
  logic [PW-1:0] old_ph;

  function automatic reg_sel_t sel_of(input logic [31:0] a);
    if (a == ADDR_DLY) begin
      sel_of = SEL_DLY;
    end else if (a == ADDR_FED) begin
      sel_of = SEL_FED;
    end else if (a == ADDR_CLF) begin
      sel_of = SEL_CLF;
    end else begin
      sel_of = SEL_NONE;
    end
  endfunction

  function automatic logic [BUS_W-1:0] read_of(input reg_sel_t s, input state_t q);
    read_of = '0;
    unique case (s)
      SEL_DLY: read_of = {{(BUS_W-REG_W){1'b0}}, q.dly};
      SEL_FED: read_of = {{(BUS_W-REG_W){1'b0}}, q.fed};
      SEL_CLF: read_of = {{(BUS_W-REG_W){1'b0}}, q.clf};
      SEL_NONE: read_of = '0;
    endcase
  endfunction

  assign addr_ok = hsel && hready && htrans[1];
  assign k_fld = st_r.dly[K_LSB +: K_W];
  assign sh_fld = st_r.fed[SH_LSB +: SH_W];
  assign ofs_fld = st_r.fed[OFS_LSB +: OFS_W];
  assign route = st_r.clf[ROUTE_BIT];
  // undefined delay codes fold onto the longest delay
  assign k_eff = (k_fld > K_MAX) ? K_MAX : k_fld;
  // the memory wraps, so a delay of DEPTH reads the slot about to be overwritten
  assign rd_addr = AW'(st_r.wptr - (AW'(1) << k_eff));
  // offset bits sit on the top five bits, the rest below are zero
  assign ofs_ext = {ofs_fld, {(PW-OFS_W){1'b0}}};

  phase_delay_mem #(
    .W(PW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_hist (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(phase_valid),
    .wr_addr(st_r.wptr),
    .wr_data(phase_in),
    .rd_en(phase_valid),
    .rd_addr(rd_addr),
    .rd_data(old_ph)
  );

  always_comb begin
    st_nxt = st_r;
    // write data phase; upper reserved bits are stored as given
    if (st_r.dp_wr) begin
      unique case (st_r.dp_sel)
        SEL_DLY: st_nxt.dly = hwdata[REG_W-1:0];
        SEL_FED: st_nxt.fed = hwdata[REG_W-1:0];
        SEL_CLF: st_nxt.clf = hwdata[REG_W-1:0];
        SEL_NONE: st_nxt.dly = st_r.dly;
      endcase
    end
    st_nxt.dp_wr = 1'b0;
    st_nxt.dp_sel = SEL_NONE;
    // read data taken from the updated copy so a write then read is coherent
    if (addr_ok) begin
      st_nxt.dp_wr = hwrite;
      st_nxt.dp_sel = sel_of(haddr);
      if (!hwrite) begin
        st_nxt.rdata = read_of(sel_of(haddr), st_nxt);
      end
    end
    // stage one: hold the present sample while the old one is fetched
    st_nxt.v1 = phase_valid;
    if (phase_valid) begin
      st_nxt.cur = phase_in;
      st_nxt.wptr = AW'(st_r.wptr + 1'b1);
    end
    // stage two: difference plus offset, modulo the word width
    st_nxt.v2 = st_r.v1;
    if (st_r.v1) begin
      st_nxt.disc = PW'(st_r.cur - old_ph + ofs_ext);
      // top bits drop off, zeros enter below; codes above four are the host's fault
      st_nxt.ferr = PW'(st_nxt.disc << sh_fld);
    end
    // serial output term follows the routing bit every cycle
    st_nxt.ser = route ? LW'(lead_in + lag_in) : lag_in;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = st_r.rdata;
  assign disc_valid = st_r.v2;
  assign disc_out = st_r.disc;
  assign ferr_out = st_r.ferr;
  assign ser_out = st_r.ser;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence two_unit_samples;
    (phase_valid && k_fld == '0 && ofs_fld == '0) ##1
    (phase_valid && k_fld == '0 && ofs_fld == '0);
  endsequence

  sequence dly_write_phase;
    addr_ok && hwrite && sel_of(haddr) == SEL_DLY ##1 1'b1;
  endsequence

  // runs of back-to-back samples let past inputs stand in for the history, one run per K;
  // a delay of sixteen would need seventeen in a row and is left to the bench
  sequence two_apart_samples;
    (phase_valid && k_fld == 3'h1 && ofs_fld == '0) [*3];
  endsequence

  sequence four_apart_samples;
    (phase_valid && k_fld == 3'h2 && ofs_fld == '0) [*5];
  endsequence

  sequence eight_apart_samples;
    (phase_valid && k_fld == 3'h3 && ofs_fld == '0) [*8] ##1
    (phase_valid && k_fld == 3'h3 && ofs_fld == '0);
  endsequence

  // register reads: the data phase shows the value left by any write that landed with it
  sequence dly_read_phase;
    addr_ok && !hwrite && haddr == ADDR_DLY;
  endsequence

  sequence fed_read_phase;
    addr_ok && !hwrite && haddr == ADDR_FED;
  endsequence

  sequence clf_read_phase;
    addr_ok && !hwrite && haddr == ADDR_CLF;
  endsequence

  sequence none_read_phase;
    addr_ok && !hwrite && haddr != ADDR_DLY && haddr != ADDR_FED &&
    haddr != ADDR_CLF;
  endsequence

  sequence fed_write_phase;
    addr_ok && hwrite && haddr == ADDR_FED ##1 1'b1;
  endsequence

  sequence clf_write_phase;
    addr_ok && hwrite && haddr == ADDR_CLF ##1 1'b1;
  endsequence

  a_valid_latency: assert property (
    phase_valid |-> ##2 disc_valid)
    else $error("discriminator result not two cycles after a sample");

  a_unit_delay: assert property (
    two_unit_samples |-> ##2
    (disc_out == PW'($past(phase_in, 2) - $past(phase_in, 3))))
    else $error("unit delay difference wrong");

  a_offset_add: assert property (
    disc_valid && $past(phase_valid, 2) && $stable(st_r.fed) |->
    (disc_out == PW'($past(st_r.cur) - $past(old_ph) +
                     {$past(ofs_fld), {(PW-OFS_W){1'b0}}})))
    else $error("offset not added on the top bits");

  a_shift_left: assert property (
    disc_valid && $stable(st_r.fed) |->
    (ferr_out == PW'(disc_out << $past(sh_fld))))
    else $error("frequency error shift wrong");

  a_shift_fill: assert property (
    disc_valid && $past(sh_fld) == SH_MAX |->
    (ferr_out[SH_MAX-1:0] == '0))
    else $error("low bits not zero filled");

  // the first edge after reset still shows the cleared term, not the sampled one
  a_route_lag: assert property (
    $past(hresetn) && !$past(route) |-> (ser_out == $past(lag_in)))
    else $error("lag term not routed alone");

  a_route_sum: assert property (
    $past(route) |-> (ser_out == LW'($past(lead_in) + $past(lag_in))))
    else $error("lead plus lag sum not routed");

  a_delay_write: assert property (
    dly_write_phase |=> (k_fld == $past(hwdata[K_LSB +: K_W])))
    else $error("delay field not taken from write");

  a_long_delay: assert property (
    (k_fld > K_MAX) |-> (k_eff == K_MAX))
    else $error("undefined delay code not folded");

  a_two_delay: assert property (
    two_apart_samples |-> ##2
    (disc_out == PW'($past(phase_in, 2) - $past(phase_in, 4))))
    else $error("two sample delay difference wrong");

  a_four_delay: assert property (
    four_apart_samples |-> ##2
    (disc_out == PW'($past(phase_in, 2) - $past(phase_in, 6))))
    else $error("four sample delay difference wrong");

  a_eight_delay: assert property (
    eight_apart_samples |-> ##2
    (disc_out == PW'($past(phase_in, 2) - $past(phase_in, 10))))
    else $error("eight sample delay difference wrong");

  a_read_dly: assert property (
    dly_read_phase |=> (hrdata == {{(BUS_W-REG_W){1'b0}}, st_r.dly}))
    else $error("delay register read back wrong");

  a_read_fed: assert property (
    fed_read_phase |=> (hrdata == {{(BUS_W-REG_W){1'b0}}, st_r.fed}))
    else $error("error detector register read back wrong");

  a_read_clf: assert property (
    clf_read_phase |=> (hrdata == {{(BUS_W-REG_W){1'b0}}, st_r.clf}))
    else $error("loop filter register read back wrong");

  a_read_none: assert property (
    none_read_phase |=> (hrdata == '0))
    else $error("unmapped read not zero");

  a_fed_write: assert property (
    fed_write_phase |=> (st_r.fed == $past(hwdata[REG_W-1:0])))
    else $error("error detector register not taken from write");

  a_clf_write: assert property (
    clf_write_phase |=> (route == $past(hwdata[ROUTE_BIT])))
    else $error("routing bit not taken from write");

  // results stand between samples so a slow consumer can pick them up late
  a_disc_hold: assert property (
    !disc_valid |-> $stable(disc_out))
    else $error("discriminator output moved without a result");

  a_ferr_hold: assert property (
    !disc_valid |-> $stable(ferr_out))
    else $error("frequency error moved without a result");

  a_valid_quiet: assert property (
    !$past(phase_valid, 2) |-> !disc_valid)
    else $error("result valid without a sample");
endmodule

// ===== verif/loop_filter_model.sv
// carrier loop filter stand-in offering fresh lead and lag terms each cycle
`timescale 1ns/1ns
module loop_filter_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // loop filter terms
  output logic [31:0] lead_out,
  output logic [31:0] lag_out
);
  // both terms move every cycle so a stale or swapped term cannot match by chance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lead_out <= 32'h8000_0001;
      lag_out <= 32'h7fff_fff3;
    end else begin
      lead_out <= lead_out + 32'h9e37_79b9;
      lag_out <= lag_out - 32'h6a09_e667;
    end
  end
endmodule

// ===== verif/carrier_freq_discriminator_cfg_tb.sv
// self-checking bench for the frequency discriminator configuration block
`timescale 1ns/1ns
module carrier_freq_discriminator_cfg_tb;
  import freq_disc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic disc_valid;
  logic [31:0] hrdata;
  logic [31:0] lead_in;
  logic [31:0] lag_in;
  logic [31:0] ser_out;
  logic [31:0] rd;
  logic phase_valid = 1'b0;
  logic [15:0] phase_in = 16'h0;
  logic [15:0] disc_out;
  logic [15:0] ferr_out;
  logic [15:0] ph = 16'h0;
  logic [15:0] hist [0:255];
  logic [2:0] k_v = 3'h0;
  logic [2:0] sh_v = 3'h0;
  logic [4:0] ofs_v = 5'h0;
  int n_smp = 0;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  always #5 hclk = ~hclk;

  carrier_freq_discriminator_cfg i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .phase_valid(phase_valid), .phase_in(phase_in), .disc_valid(disc_valid),
    .disc_out(disc_out), .ferr_out(ferr_out), .lead_in(lead_in), .lag_in(lag_in),
    .ser_out(ser_out)
  );

  loop_filter_model i_lf (
    .hclk(hclk), .hresetn(hresetn), .lead_out(lead_in), .lag_out(lag_in)
  );

  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run needs about 510 cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= TR_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // expectation comes from the bench's own copy of every sample since reset
  task automatic send(input logic [15:0] v);
    logic [15:0] e;
    int dl;
    dl = 1 << k_v;
    hist[n_smp] = v;
    e = v - ((n_smp >= dl) ? hist[n_smp - dl] : 16'h0) + {ofs_v, 11'h0};
    n_smp++;
    @(posedge hclk);
    phase_valid <= 1'b1;
    phase_in <= v;
    @(posedge hclk);
    phase_valid <= 1'b0;
    @(posedge hclk);
    #1;
    chk("disc_valid", 32'h1, {31'h0, disc_valid});
    chk("disc_out", {16'h0, e}, {16'h0, disc_out});
    chk("ferr_out", {16'h0, 16'(e << sh_v)}, {16'h0, ferr_out});
  endtask

  task automatic t_regs;
    rdchk("dly_rst", ADDR_DLY, 32'h0);
    rdchk("fed_rst", ADDR_FED, 32'h0);
    rdchk("clf_rst", ADDR_CLF, 32'h0);
    bus(1'b1, ADDR_DLY, 32'hffff_ff07);
    rdchk("dly", ADDR_DLY, 32'h7);
    bus(1'b1, ADDR_FED, 32'h0000_00a4);
    rdchk("fed", ADDR_FED, 32'ha4);
    bus(1'b1, ADDR_CLF, 32'h0000_0040);
    rdchk("clf", ADDR_CLF, 32'h40);
    bus(1'b1, ADDR_CLF + 32'h4, 32'h0000_005a);
    rdchk("unmapped", ADDR_CLF + 32'h4, 32'h0);
  endtask

  task automatic t_disc;
    bus(1'b1, ADDR_FED, 32'h0);
    for (int i = 0; i < 5; i++) begin
      k_v = i[2:0];
      bus(1'b1, ADDR_DLY, {29'h0, k_v});
      for (int j = 0; j < 18; j++) begin
        ph = ph + 16'h0d31;
        send(ph);
      end
    end
  endtask

  task automatic t_ofs;
    k_v = 3'h1;
    bus(1'b1, ADDR_DLY, 32'h1);
    for (int i = 0; i < 3; i++) begin
      for (int s = 0; s < 5; s++) begin
        ofs_v = (i == 0) ? 5'h10 : ((i == 1) ? 5'h0f : 5'h01);
        sh_v = s[2:0];
        bus(1'b1, ADDR_FED, {24'h0, ofs_v, sh_v});
        ph = ph + 16'h3a7b;
        send(ph);
      end
    end
  endtask

  // back-to-back samples for each short delay; a result comes out every cycle
  task automatic t_burst;
    logic [15:0] ex [0:9];
    bus(1'b1, ADDR_FED, 32'h0);
    for (int k = 0; k < 4; k++) begin
      k_v = k[2:0];
      bus(1'b1, ADDR_DLY, {29'h0, k_v});
      for (int j = 0; j < 12; j++) begin
        @(posedge hclk);
        if (j < 10) begin
          ph = ph + 16'h1f0b;
          hist[n_smp] = ph;
          ex[j] = ph - ((n_smp >= (1 << k)) ? hist[n_smp - (1 << k)] : 16'h0);
          n_smp++;
        end
        phase_valid <= (j < 10);
        phase_in <= ph;
        #1;
        if (j >= 2) begin
          chk("burst_valid", 32'h1, {31'h0, disc_valid});
          chk("burst_out", {16'h0, ex[j - 2]}, {16'h0, disc_out});
        end
      end
    end
  endtask

  task automatic t_ser;
    logic [31:0] a;
    logic [31:0] b;
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, ADDR_CLF, {25'h0, r[0], 6'h0});
      repeat (4) begin
        @(negedge hclk);
        a = lead_in;
        b = lag_in;
        @(posedge hclk);
        #1;
        chk("ser_out", (r == 1) ? a + b : b, ser_out);
      end
    end
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_disc;
    t_ofs;
    t_burst;
    t_ser;
    stop_test;
  end
endmodule
